// >>> iod_pkg.sv
`default_nettype none
package iod_pkg;

  // --------------------------------------------------------------
  // Address windows
  // --------------------------------------------------------------
  localparam logic [7:0] IO_LOW_LAST = 8'h1f;
  localparam logic [7:0] IO_LAST = 8'h3f;
  localparam logic [7:0] IO_DATA_OFFSET = 8'h20;
  localparam logic [7:0] EXT_FIRST = 8'h60;
  localparam int unsigned LOW_COUNT = 32;

  // --------------------------------------------------------------
  // Register indices in the bit-accessible window
  // --------------------------------------------------------------
  localparam logic [4:0] ADDR_PORT_B_INPUT_PINS = 5'h03;
  localparam logic [4:0] ADDR_PORT_B_DIRECTION = 5'h04;
  localparam logic [4:0] ADDR_PORT_B_OUTPUT = 5'h05;
  localparam logic [4:0] ADDR_PORT_C_INPUT_PINS = 5'h06;
  localparam logic [4:0] ADDR_PORT_C_DIRECTION = 5'h07;
  localparam logic [4:0] ADDR_PORT_C_OUTPUT = 5'h08;
  localparam logic [4:0] ADDR_PORT_D_INPUT_PINS = 5'h09;
  localparam logic [4:0] ADDR_PORT_D_DIRECTION = 5'h0a;
  localparam logic [4:0] ADDR_PORT_D_OUTPUT = 5'h0b;
  localparam logic [4:0] ADDR_TIMER0_FLAGS = 5'h15;
  localparam logic [4:0] ADDR_TIMER1_FLAGS = 5'h16;
  localparam logic [4:0] ADDR_TIMER2_FLAGS = 5'h17;
  localparam logic [4:0] ADDR_PIN_CHANGE_FLAGS = 5'h1b;
  localparam logic [4:0] ADDR_EXT_INTERRUPT_FLAGS = 5'h1c;
  localparam logic [4:0] ADDR_EXT_INTERRUPT_MASK = 5'h1d;

  // --------------------------------------------------------------
  // Implemented bit masks and reset value
  // --------------------------------------------------------------
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_ALL = 8'hff;
  localparam logic [7:0] MASK_PORT_C = 8'h7f;
  localparam logic [7:0] MASK_TIMER0_FLAGS = 8'h07;
  localparam logic [7:0] MASK_TIMER1_FLAGS = 8'h27;
  localparam logic [7:0] MASK_TIMER2_FLAGS = 8'h07;
  localparam logic [7:0] MASK_PIN_CHANGE_FLAGS = 8'h07;
  localparam logic [7:0] MASK_EXT_INTERRUPT = 8'h03;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam logic [7:0] BIT_ZERO = 8'h01;

  // --------------------------------------------------------------
  // Types
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_IN, OP_OUT, OP_SET_BIT, OP_CLEAR_BIT,
    OP_SKIP_IF_BIT_SET, OP_SKIP_IF_BIT_CLEAR, OP_LOAD, OP_STORE
  } iod_op_t;

  typedef struct packed {
    iod_op_t op;
    logic [7:0] addr;
    logic [2:0] bitSel;
    logic [7:0] wdata;
  } iod_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic skipTaken;
    logic accessError;
  } iod_resp_t;

  typedef struct packed {
    logic [7:0] timer0;
    logic [7:0] timer1;
    logic [7:0] timer2;
    logic [7:0] pinChange;
    logic [7:0] extInt;
  } iod_flag_evt_t;

  typedef struct packed {
    logic [7:0] dirB;
    logic [7:0] outB;
    logic [7:0] dirC;
    logic [7:0] outC;
    logic [7:0] dirD;
    logic [7:0] outD;
  } iod_port_ctrl_t;

  // Bits that software reads and writes as plain storage
  function automatic logic [7:0] rwMask(input logic [4:0] idx);
    case (idx)
      ADDR_PORT_B_DIRECTION, ADDR_PORT_B_OUTPUT: rwMask = MASK_ALL;
      ADDR_PORT_D_DIRECTION, ADDR_PORT_D_OUTPUT: rwMask = MASK_ALL;
      ADDR_PORT_C_DIRECTION, ADDR_PORT_C_OUTPUT: rwMask = MASK_PORT_C;
      ADDR_EXT_INTERRUPT_MASK: rwMask = MASK_EXT_INTERRUPT;
      default: rwMask = MASK_NONE;
    endcase
  endfunction : rwMask

  // Status flags that hardware sets and a written one clears
  function automatic logic [7:0] w1cMask(input logic [4:0] idx);
    case (idx)
      ADDR_TIMER0_FLAGS: w1cMask = MASK_TIMER0_FLAGS;
      ADDR_TIMER1_FLAGS: w1cMask = MASK_TIMER1_FLAGS;
      ADDR_TIMER2_FLAGS: w1cMask = MASK_TIMER2_FLAGS;
      ADDR_PIN_CHANGE_FLAGS: w1cMask = MASK_PIN_CHANGE_FLAGS;
      ADDR_EXT_INTERRUPT_FLAGS: w1cMask = MASK_EXT_INTERRUPT;
      default: w1cMask = MASK_NONE;
    endcase
  endfunction : w1cMask

endpackage : iod_pkg
`default_nettype wire

// >>> iod_io_space_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module iod_io_space_decoder
  import iod_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic reqValid,
  input wire iod_req_t req,
  output logic respValid,
  output iod_resp_t resp,
  input wire logic [7:0] pinsB,
  input wire logic [7:0] pinsC,
  input wire logic [7:0] pinsD,
  input wire iod_flag_evt_t flagEvents,
  output iod_port_ctrl_t portCtrl,
  output logic [7:0] extIntMask,
  output logic extValid,
  output logic extWrite,
  output logic [7:0] extAddr,
  output logic [7:0] extWdata,
  input wire logic [7:0] extRdata
);

  // ------------------------------------------------------------
  // Storage and pin synchronisers
  // ------------------------------------------------------------
  logic [7:0] regFile_reg [LOW_COUNT];
  logic [7:0] regFile_next [LOW_COUNT];
  logic [23:0] pinMeta_reg;
  logic [23:0] pinSync_reg;
  logic respValid_reg;
  iod_resp_t resp_reg;

  // Decode results
  logic ioHit;
  logic extHit;
  logic lowHit;
  logic [5:0] ioIdx;
  logic [4:0] lowIdx;
  logic isWrite;
  logic lowWrite;
  logic [7:0] bitOne;
  logic [7:0] oldVal;
  logic [7:0] rwVal;
  logic [7:0] clrVal;
  logic [7:0] rdData;
  logic skipTaken;

  // Pins come from outside the clock domain; only stage two is read
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pinMeta_reg <= 24'h000000;
      pinSync_reg <= 24'h000000;
    end else begin
      pinMeta_reg <= {pinsD, pinsC, pinsB};
      pinSync_reg <= pinMeta_reg;
    end
  end

  // ------------------------------------------------------------
  // Address decode per access type
  // ------------------------------------------------------------
  always_comb begin
    ioHit = 1'b0;
    extHit = 1'b0;
    ioIdx = 6'h00;
    unique case (req.op)
      OP_IN, OP_OUT: begin
        if (req.addr <= IO_LAST) begin
          ioHit = 1'b1;
          ioIdx = req.addr[5:0];
        end
      end
      OP_SET_BIT, OP_CLEAR_BIT, OP_SKIP_IF_BIT_SET,
      OP_SKIP_IF_BIT_CLEAR: begin
        if (req.addr <= IO_LOW_LAST) begin
          ioHit = 1'b1;
          ioIdx = req.addr[5:0];
        end
      end
      OP_LOAD, OP_STORE: begin
        if (req.addr >= EXT_FIRST) begin
          extHit = 1'b1;
        end else if (req.addr >= IO_DATA_OFFSET) begin
          ioHit = 1'b1;
          ioIdx = 6'(req.addr - IO_DATA_OFFSET);
        end
      end
    endcase
  end

  // Upper I/O half belongs to other peripherals and is not held here
  assign lowHit = ioHit && !ioIdx[5];
  assign lowIdx = ioIdx[4:0];
  assign isWrite = (req.op == OP_OUT) || (req.op == OP_STORE) ||
                   (req.op == OP_SET_BIT) || (req.op == OP_CLEAR_BIT);
  assign lowWrite = reqValid && lowHit && isWrite;
  assign bitOne = BIT_ZERO << req.bitSel;
  assign oldVal = regFile_reg[lowIdx];

  // ------------------------------------------------------------
  // Write value forming
  // ------------------------------------------------------------
  // A bit set writes a one into the addressed bit alone, so on a
  // flag register it clears only that flag and leaves its peers.
  always_comb begin
    unique case (req.op)
      OP_OUT, OP_STORE: begin
        rwVal = req.wdata;
        clrVal = req.wdata;
      end
      OP_SET_BIT: begin
        rwVal = oldVal | bitOne;
        clrVal = bitOne;
      end
      OP_CLEAR_BIT: begin
        rwVal = oldVal & ~bitOne;
        clrVal = MASK_NONE;
      end
      default: begin
        rwVal = oldVal;
        clrVal = MASK_NONE;
      end
    endcase
  end

  // Hardware flag events for a given index
  function automatic logic [7:0] eventsFor(input logic [4:0] idx,
                                           input iod_flag_evt_t ev);
    case (idx)
      ADDR_TIMER0_FLAGS: eventsFor = ev.timer0;
      ADDR_TIMER1_FLAGS: eventsFor = ev.timer1;
      ADDR_TIMER2_FLAGS: eventsFor = ev.timer2;
      ADDR_PIN_CHANGE_FLAGS: eventsFor = ev.pinChange;
      ADDR_EXT_INTERRUPT_FLAGS: eventsFor = ev.extInt;
      default: eventsFor = MASK_NONE;
    endcase
  endfunction : eventsFor

  // ------------------------------------------------------------
  // Register next state
  // ------------------------------------------------------------
  // Masks keep unimplemented bits at zero; an event in the same
  // cycle as its clear wins, so no flag is ever lost.
  always_comb begin
    for (int i = 0; i < LOW_COUNT; i++) begin
      regFile_next[i] = (regFile_reg[i] &
                         (rwMask(5'(i)) | w1cMask(5'(i)))) |
                        (eventsFor(5'(i), flagEvents) & w1cMask(5'(i)));
      if (lowWrite && (lowIdx == 5'(i))) begin
        regFile_next[i] = (rwVal & rwMask(5'(i))) |
                          (regFile_reg[i] & w1cMask(5'(i)) & ~clrVal) |
                          (eventsFor(5'(i), flagEvents) &
                           w1cMask(5'(i)));
      end
    end
  end

  // Low window storage
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < LOW_COUNT; i++) begin
        regFile_reg[i] <= RESET_VALUE;
      end
    end else begin
      for (int i = 0; i < LOW_COUNT; i++) begin
        regFile_reg[i] <= regFile_next[i];
      end
    end
  end

  // ------------------------------------------------------------
  // Read path and bit test
  // ------------------------------------------------------------
  always_comb begin
    rdData = RESET_VALUE;
    if (lowHit) begin
      unique case (lowIdx)
        ADDR_PORT_B_INPUT_PINS: rdData = pinSync_reg[7:0];
        ADDR_PORT_C_INPUT_PINS: rdData = pinSync_reg[15:8] & MASK_PORT_C;
        ADDR_PORT_D_INPUT_PINS: rdData = pinSync_reg[23:16];
        default: rdData = regFile_reg[lowIdx] &
                          (rwMask(lowIdx) | w1cMask(lowIdx));
      endcase
    end else if (extHit) begin
      rdData = extRdata;
    end
  end

  // Skip answer only exists inside the bit-accessible window
  always_comb begin
    skipTaken = 1'b0;
    if (lowHit && (req.op == OP_SKIP_IF_BIT_SET)) begin
      skipTaken = |(rdData & bitOne);
    end else if (lowHit && (req.op == OP_SKIP_IF_BIT_CLEAR)) begin
      skipTaken = ~|(rdData & bitOne);
    end
  end

  // ------------------------------------------------------------
  // Answer registers
  // ------------------------------------------------------------
  // One-cycle latency keeps read data and skip result off the
  // combinational path back into the core.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      respValid_reg <= 1'b0;
      resp_reg <= '0;
    end else begin
      respValid_reg <= reqValid;
      if (reqValid) begin
        resp_reg.rdata <= isWrite ? RESET_VALUE : rdData;
        resp_reg.skipTaken <= skipTaken;
        resp_reg.accessError <= !(ioHit || extHit);
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign respValid = respValid_reg;
  assign resp = resp_reg;
  assign portCtrl.dirB = regFile_reg[ADDR_PORT_B_DIRECTION];
  assign portCtrl.outB = regFile_reg[ADDR_PORT_B_OUTPUT];
  assign portCtrl.dirC = regFile_reg[ADDR_PORT_C_DIRECTION];
  assign portCtrl.outC = regFile_reg[ADDR_PORT_C_OUTPUT];
  assign portCtrl.dirD = regFile_reg[ADDR_PORT_D_DIRECTION];
  assign portCtrl.outD = regFile_reg[ADDR_PORT_D_OUTPUT];
  assign extIntMask = regFile_reg[ADDR_EXT_INTERRUPT_MASK];

  // Extended space strobe; address and data pass straight through
  assign extValid = reqValid && extHit;
  assign extWrite = req.op == OP_STORE;
  assign extAddr = req.addr;
  assign extWdata = req.wdata;

endmodule : iod_io_space_decoder
`default_nettype wire

// >>> iod_io_space_decoder_checker.sv
`timescale 1ns/1ps
`default_nettype none
module iod_io_space_decoder_checker
  import iod_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic reqValid,
  input wire iod_req_t req,
  input wire logic respValid,
  input wire iod_resp_t resp,
  input wire iod_port_ctrl_t portCtrl,
  input wire logic [7:0] extIntMask,
  input wire logic extValid,
  input wire logic [7:0] extRdata
);
  // ------------------------------------------------
  // Request classes and sequences
  // ------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic isLdSt = req.op inside {OP_LOAD, OP_STORE};
  wire logic isBit = req.op inside {OP_SET_BIT, OP_CLEAR_BIT,
    OP_SKIP_IF_BIT_SET, OP_SKIP_IF_BIT_CLEAR};
  sequence s_ext_load;
    reqValid && req.op == OP_LOAD && req.addr >= EXT_FIRST;
  endsequence
  sequence s_mask_skip;
    reqValid && req.op == OP_SKIP_IF_BIT_SET && req.addr == 8'h1d;
  endsequence
  // ------------------------------------------------
  // Assertions
  // ------------------------------------------------
  a_resp_pulse: assert property (reqValid |=> respValid)
    else $error("answer missing");
  a_resp_quiet: assert property (!reqValid |=> !respValid)
    else $error("answer without request");
  a_ext_strobe: assert property (extValid ==
    (reqValid && isLdSt && req.addr >= EXT_FIRST))
    else $error("extended strobe wrong");
  a_ext_data: assert property (s_ext_load |=>
    resp.rdata == $past(extRdata)) else $error("extended data lost");
  a_in_refused: assert property (reqValid && req.op == OP_IN &&
    req.addr > IO_LAST |=> resp.accessError && resp.rdata == 8'h00)
    else $error("in beyond window accepted");
  a_bit_range: assert property (reqValid && isBit &&
    req.addr > IO_LOW_LAST |=> resp.accessError)
    else $error("bit op beyond low window accepted");
  a_load_low: assert property (reqValid && isLdSt &&
    req.addr < IO_DATA_OFFSET |=> resp.accessError)
    else $error("load below offset accepted");
  a_store_map: assert property (reqValid && req.op == OP_STORE &&
    req.addr == 8'h25 |=> portCtrl.outB == $past(req.wdata))
    else $error("store not mapped to port b output");
  a_skip_mask: assert property (s_mask_skip |=>
    resp.skipTaken == extIntMask[$past(req.bitSel)])
    else $error("skip result wrong");
  a_resv_bits: assert property (portCtrl.dirC[7] == 1'b0 &&
    portCtrl.outC[7] == 1'b0 && extIntMask[7:2] == 6'h00)
    else $error("reserved bit set");
endmodule : iod_io_space_decoder_checker
bind iod_io_space_decoder iod_io_space_decoder_checker
  iod_io_space_decoder_checker_inst (.clock, .resetn, .reqValid, .req,
  .respValid, .resp, .portCtrl, .extIntMask, .extValid, .extRdata);
`default_nettype wire

// >>> iod_ext_mem.sv
`timescale 1ns/1ps
`default_nettype none
module iod_ext_mem (
  input wire logic clock,
  input wire logic extValid,
  input wire logic extWrite,
  input wire logic [7:0] extAddr,
  input wire logic [7:0] extWdata,
  output logic [7:0] extRdata
);
  logic [7:0] mem [256];
  logic [7:0] lastReg;
  // Store at the edge that takes the request
  always @(posedge clock) begin
    if (extValid && extWrite) mem[extAddr] <= extWdata;
    if (extValid) lastReg <= extRdata;
  end
  // Unselected: inverse of last value, so a stale sample shows
  assign extRdata = extValid ? mem[extAddr] : ~lastReg;
  initial begin
    lastReg = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
  end
endmodule : iod_ext_mem
`default_nettype wire

// >>> tb_iod_io_space_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_iod_io_space_decoder
  import iod_pkg::*;
;
  logic clock, resetn, reqValid, respValid, extValid, extWrite;
  iod_req_t req;
  iod_resp_t resp;
  logic [7:0] pinsB, pinsC, pinsD, extIntMask, extAddr, extWdata, extRdata;
  iod_flag_evt_t flagEvents;
  iod_port_ctrl_t portCtrl;
  logic [7:0] sh [32];
  logic [7:0] em [256];
  logic [31:0] seed = 32'h000170b2;
  int n_mismatch, samples_checked;
  iod_io_space_decoder iod_io_space_decoder_inst (.clock, .resetn,
    .reqValid, .req, .respValid, .resp, .pinsB, .pinsC, .pinsD,
    .flagEvents, .portCtrl, .extIntMask, .extValid, .extWrite, .extAddr,
    .extWdata, .extRdata);
  iod_ext_mem iod_ext_mem_inst (.clock, .extValid, .extWrite, .extAddr,
    .extWdata, .extRdata);
  // ------------------------------------------------
  // Reference model
  // ------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [7:0] wm(input logic [4:0] i);
    case (i)
      5'h04, 5'h05, 5'h0a, 5'h0b: return 8'hff;
      5'h07, 5'h08: return 8'h7f;
      5'h1d: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction : wm
  function automatic logic [7:0] fm(input logic [4:0] i);
    case (i)
      5'h15, 5'h17, 5'h1b: return 8'h07;
      5'h16: return 8'h27;
      5'h1c: return 8'h03;
      default: return 8'h00;
    endcase
  endfunction : fm
  // Bits with a meaning; zero marks a reserved bit or address
  function automatic logic [7:0] im(input logic [4:0] i);
    case (i)
      5'h03, 5'h09: return 8'hff;
      5'h06: return 8'h7f;
      default: return wm(i) | fm(i);
    endcase
  endfunction : im
  function automatic logic [7:0] rd(input logic [4:0] i);
    case (i)
      5'h03: return pinsB;
      5'h06: return pinsC & 8'h7f;
      5'h09: return pinsD;
      default: return sh[i];
    endcase
  endfunction : rd
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic complete_run();
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // One flag event cycle with the bus idle
  task automatic pulse();
    reqValid = 1'b0;
    flagEvents = '1;
    @(posedge clock);
    #1 flagEvents = '0;
    foreach (sh[i]) sh[i] = sh[i] | fm(5'(i));
  endtask : pulse
  // One access; reqValid stays up so accesses run back to back
  task automatic acc(input iod_op_t op, input logic [7:0] a,
      input logic [2:0] b, input logic [7:0] wd);
    logic [7:0] io, x, m;
    logic err, ext, low, sk;
    io = (op >= OP_LOAD) ? a - 8'h20 : a;
    err = (op inside {OP_IN, OP_OUT}) ? a > 8'h3f :
      (op >= OP_LOAD) ? a < 8'h20 : a > 8'h1f;
    ext = op >= OP_LOAD && a >= 8'h60;
    low = !err && !ext && io <= 8'h1f;
    m = 8'h01 << b;
    x = low ? rd(io[4:0]) : ext ? em[a] : 8'h00;
    sk = (op == OP_SKIP_IF_BIT_SET) ? x[b] : !x[b];
    reqValid = 1'b1;
    req = '{op: op, addr: a, bitSel: b, wdata: wd};
    @(posedge clock);
    #1;
    chk(48'(respValid), 48'h1);
    chk(48'(resp.accessError), 48'(err));
    case (op)
      OP_IN, OP_LOAD: chk(48'(resp.rdata), 48'(x));
      OP_OUT, OP_STORE: begin
        chk(48'(resp.rdata), 48'h0);
        if (low) sh[io[4:0]] = (sh[io[4:0]] & ~wm(io[4:0])
          & ~(wd & fm(io[4:0]))) | (wd & wm(io[4:0]));
        if (ext) em[a] = wd;
      end
      OP_SET_BIT: if (low) sh[io[4:0]] = (sh[io[4:0]]
        & ~(m & fm(io[4:0]))) | (m & wm(io[4:0]));
      OP_CLEAR_BIT: if (low) sh[io[4:0]] = sh[io[4:0]] & ~(m & wm(io[4:0]));
      default: if (!err) chk(48'(resp.skipTaken), 48'(sk));
    endcase
  endtask : acc
  // ------------------------------------------------
  // Stimulus
  // ------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    complete_run();
  end
  initial begin : main
    logic [31:0] r;
    logic [7:0] a;
    iod_op_t op;
    logic [7:0] wd, io, m;
    resetn = 1'b0;
    reqValid = 1'b0;
    req = '0;
    flagEvents = '0;
    r = rnd();
    {pinsB, pinsC, pinsD} = r[23:0];
    foreach (sh[i]) sh[i] = 8'h00;
    foreach (em[i]) em[i] = 8'h00;
    repeat (16) @(posedge clock);
    #1 resetn = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    for (int i = 0; i < 64; i++) acc(OP_IN, 8'(i), 3'h0, 8'h00);
    pulse();
    acc(OP_SET_BIT, 8'h16, 3'h5, 8'h00);
    acc(OP_CLEAR_BIT, 8'h15, 3'h0, 8'h00);
    acc(OP_STORE, 8'h35, 3'h0, 8'h05);
    acc(OP_IN, 8'h15, 3'h0, 8'h00);
    acc(OP_IN, 8'h16, 3'h0, 8'h00);
    acc(OP_STORE, 8'h25, 3'h0, 8'ha5);
    acc(OP_STORE, 8'h3d, 3'h0, 8'hff);
    acc(OP_SKIP_IF_BIT_SET, 8'h1d, 3'h1, 8'h00);
    acc(OP_IN, 8'h60, 3'h0, 8'h00);
    acc(OP_STORE, 8'h9f, 3'h0, 8'h3c);
    acc(OP_LOAD, 8'h9f, 3'h0, 8'h00);
    acc(OP_SET_BIT, 8'h20, 3'h0, 8'h00);
    acc(OP_OUT, 8'h1a, 3'h0, 8'hff);
    for (int i = 0; i < 400; i++) begin
      if (i % 40 == 0) pulse();
      r = rnd();
      a = r[15:8];
      if (r[7:6] != 2'b00) a = {3'b000, a[4:0]};
      if (r[2] && r[1] && r[7:6] != 2'b00)
        a = (r[7:6] == 2'b11) ? a | 8'h80 : a + 8'h20;
      op = iod_op_t'(r[2:0]);
      wd = r[31:24];
      io = (op >= OP_LOAD) ? a - 8'h20 : a;
      // Random software stays polite: the corner cases above probe
      // reserved writes, the bulk traffic never makes them.
      if (op inside {OP_OUT, OP_STORE, OP_SET_BIT, OP_CLEAR_BIT} &&
          io <= 8'h1f) begin
        m = im(io[4:0]);
        if (m == 8'h00) op = (op >= OP_LOAD) ? OP_LOAD : OP_IN;
        if (op == OP_SET_BIT && !m[r[18:16]]) op = OP_CLEAR_BIT;
        wd = wd & m;
      end
      acc(op, a, r[18:16], wd);
    end
    reqValid = 1'b0;
    chk(portCtrl, {sh[4], sh[5], sh[7], sh[8], sh[10], sh[11]});
    chk(48'(extIntMask), 48'(sh[29]));
    complete_run();
  end
endmodule : tb_iod_io_space_decoder
`default_nettype wire
